// ### hdl/bscan_adc_pkg.sv
package bscan_adc_pkg;

    localparam int CHAIN_LEN  = 198;
    localparam int LEVEL_W    = 10;
    localparam int CHAN_W     = 8;
    localparam int PORT_PINS  = 8;
    localparam int CELLS_PIN  = 3;

    // Analog cells sit at the top of the chain
    localparam int POS_ANALOG_LO = 158;
    localparam int POS_ANALOG_HI = 197;
    localparam int ANALOG_W      = POS_ANALOG_HI - POS_ANALOG_LO + 1;
    localparam int POS_IDLE      = 197;
    localparam int POS_VERDICT   = 193;
    localparam int POS_CONV_ON   = 188;
    localparam int POS_LEVEL_LO  = 177;
    localparam int POS_GNDEN     = 175;
    localparam int POS_HOLD      = 174;
    localparam int POS_CHAN_LO   = 165;
    localparam int POS_PASSEN    = 161;
    localparam int POS_PRELOAD   = 160;
    localparam int POS_BANDGAP   = 194;
    localparam int POS_NEGMUX    = 195;

    // Cell group of a port pin: data, direction, pull-up
    localparam int FLOP_DATA   = 0;
    localparam int FLOP_DIR    = 1;
    localparam int FLOP_PULLUP = 2;
    localparam int PORTA_BASE  = 0;
    localparam int PORTA_W     = PORT_PINS * CELLS_PIN;
    localparam int SHARED_PIN  = 3;

    // Idle values: keep, channel 0 bit, pass gate and preload high
    localparam logic [CHAIN_LEN-1:0] CHAIN_RESET =
        (CHAIN_LEN'(1) << POS_HOLD) | (CHAIN_LEN'(1) << POS_CHAN_LO) |
        (CHAIN_LEN'(1) << POS_PASSEN) | (CHAIN_LEN'(1) << POS_PRELOAD);

    localparam logic [LEVEL_W-1:0] LEVEL_MID  = 10'h200;
    localparam logic [CHAN_W-1:0]  CHAN_EXAMPLE = 8'h08;

    localparam logic [3:0] STEP_FIRST     = 4'h1;
    localparam logic [3:0] STEP_LO_SAMPLE = 4'h2;
    localparam logic [3:0] STEP_LO_APPLY  = 4'h4;
    localparam logic [3:0] STEP_LO_PRE    = 4'h5;
    localparam logic [3:0] STEP_LO_CHECK  = 4'h6;
    localparam logic [3:0] STEP_HI_SAMPLE = 4'h7;
    localparam logic [3:0] STEP_HI_APPLY  = 4'h9;
    localparam logic [3:0] STEP_HI_PRE    = 4'hA;
    localparam logic [3:0] STEP_HI_CHECK  = 4'hB;

    localparam int CLK_NS       = 40;
    localparam int SETTLE_NS    = 200;
    localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DUMMY_COMPS  = 10;
    localparam int TCK_HALF_CYC = 4;

    // Port A runs in reversed bit order against the other ports
    function automatic int pinCellPos(input int pin, input int flop);
        return PORTA_BASE + (PORT_PINS - 1 - pin) * CELLS_PIN + flop;
    endfunction : pinCellPos

    function automatic logic [CHAIN_LEN-1:0] limitPattern(
        input logic [3:0]         step,
        input logic [LEVEL_W-1:0] lo,
        input logic [LEVEL_W-1:0] hi,
        input logic [CHAN_W-1:0]  chan);
        logic [CHAIN_LEN-1:0] v;
        v = CHAIN_RESET;
        v[POS_CONV_ON] = 1'b1;
        v[POS_CHAN_LO +: CHAN_W] = chan;
        // Only the channel feeds the negative path: ground and bandgap stay off
        v[POS_GNDEN] = 1'b0;
        v[POS_BANDGAP] = 1'b0;
        v[POS_LEVEL_LO +: LEVEL_W] = LEVEL_MID;
        if (step == STEP_LO_APPLY || step == STEP_LO_PRE) begin
            v[POS_LEVEL_LO +: LEVEL_W] = lo;
        end
        if (step == STEP_HI_APPLY || step == STEP_HI_PRE) begin
            v[POS_LEVEL_LO +: LEVEL_W] = hi;
        end
        if (step == STEP_LO_SAMPLE || step == STEP_HI_SAMPLE) begin
            v[POS_HOLD] = 1'b0;
        end
        if (step == STEP_LO_PRE || step == STEP_HI_PRE) begin
            v[POS_PRELOAD] = 1'b0;
        end
        v[pinCellPos(SHARED_PIN, FLOP_DATA)] = 1'b0;
        v[pinCellPos(SHARED_PIN, FLOP_DIR)] = 1'b0;
        v[pinCellPos(SHARED_PIN, FLOP_PULLUP)] = 1'b0;
        return v;
    endfunction : limitPattern

endpackage : bscan_adc_pkg

// ### hdl/bscan_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bscan_link_if;
    logic tck;
    logic tdi;
    logic tdo;
    logic instrExtest;
    logic capture;
    logic shift;
    logic update;

    modport device (input tck, input tdi, input instrExtest, input capture,
                    input shift, input update, output tdo);
    modport tester (output tck, output tdi, output instrExtest, output capture,
                    output shift, output update, input tdo);
endinterface : bscan_link_if
`default_nettype wire

// ### hdl/bscan_adc_device.sv
`timescale 1ns/1ns
`default_nettype none
module bscan_adc_device
    import bscan_adc_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              nrst,
    bscan_link_if.device                           link,
    input  wire logic                              compIn,
    input  wire logic                              normConvOn,
    input  wire logic [bscan_adc_pkg::PORT_PINS-1:0] portAIn,
    output logic                                   extestActive,
    output logic                                   convOn,
    output logic [bscan_adc_pkg::LEVEL_W-1:0]      testLevel,
    output logic                                   holdKeep,
    output logic                                   sampleTrack,
    output logic [bscan_adc_pkg::CHAN_W-1:0]       chanSel,
    output logic                                   preloadN,
    output logic                                   gndNeg,
    output logic                                   bandgapNeg,
    output logic                                   negMuxSel,
    output logic                                   dummyBusy,
    output logic [bscan_adc_pkg::PORT_PINS-1:0]    portAData,
    output logic [bscan_adc_pkg::PORT_PINS-1:0]    portADir,
    output logic [bscan_adc_pkg::PORT_PINS-1:0]    portAPullup
);
    import bscan_adc_pkg::*;

    // Link bit order in the synchroniser vectors
    localparam int L_TCK = 5;
    localparam int L_TDI = 4;
    localparam int L_EXT = 3;
    localparam int L_CAP = 2;
    localparam int L_SHF = 1;
    localparam int L_UPD = 0;

    typedef struct packed {
        logic [5:0]           linkS1;
        logic [5:0]           linkS2;
        logic                 tckPrev;
        logic                 compS1;
        logic                 compS2;
        logic [PORT_PINS-1:0] pinS1;
        logic [PORT_PINS-1:0] pinS2;
        logic [CHAIN_LEN-1:0] chain;
        logic [CHAIN_LEN-1:0] upd;
        logic                 tdo;
        logic                 extest;
        logic [ANALOG_W-1:0]  aOut;
        logic                 track;
        logic [PORTA_W-1:0]   pOut;
        logic                 convPrev;
        logic [3:0]           compCount;
        logic                 busy;
    } dev_state_t;

    // Chain and update stage start at the idle pattern, so an extest with no
    // preload before it still drives safe values into the converter
    localparam dev_state_t DEV_RESET = '{
        linkS1:    6'h00,
        linkS2:    6'h00,
        tckPrev:   1'b0,
        compS1:    1'b0,
        compS2:    1'b0,
        pinS1:     '0,
        pinS2:     '0,
        chain:     CHAIN_RESET,
        upd:       CHAIN_RESET,
        tdo:       1'b0,
        extest:    1'b0,
        aOut:      CHAIN_RESET[POS_ANALOG_HI:POS_ANALOG_LO],
        track:     1'b0,
        pOut:      '0,
        convPrev:  1'b0,
        compCount: 4'h0,
        busy:      1'b0
    };

    dev_state_t s_reg;
    dev_state_t s_next;

    logic tckRise;
    logic tckFall;

    function automatic logic analogBit(input logic [ANALOG_W-1:0] a, input int pos);
        return a[pos - POS_ANALOG_LO];
    endfunction : analogBit

    // Analog slice shown while the tester does not own the cells
    function automatic logic [ANALOG_W-1:0] normalSlice(input logic conv,
                                                        input logic comp,
                                                        input logic idle);
        logic [ANALOG_W-1:0] a;
        a = CHAIN_RESET[POS_ANALOG_HI:POS_ANALOG_LO];
        a[POS_CONV_ON - POS_ANALOG_LO] = conv;
        a[POS_VERDICT - POS_ANALOG_LO] = comp;
        a[POS_IDLE - POS_ANALOG_LO]    = idle;
        return a;
    endfunction : normalSlice

    // All link levels pass the same two flops, so tdi and the phase bits are
    // settled when the late tck edge is seen; the cost is three clocks of lag
    assign tckRise = s_reg.linkS2[L_TCK] & ~s_reg.tckPrev;
    assign tckFall = ~s_reg.linkS2[L_TCK] & s_reg.tckPrev;

    always_comb begin
        s_next = s_reg;
        s_next.linkS1 = {link.tck, link.tdi, link.instrExtest,
                         link.capture, link.shift, link.update};
        s_next.linkS2 = s_reg.linkS1;
        s_next.tckPrev = s_reg.linkS2[L_TCK];
        s_next.compS1 = compIn;
        s_next.compS2 = s_reg.compS1;
        s_next.pinS1 = portAIn;
        s_next.pinS2 = s_reg.pinS1;

        if (tckRise) begin
            if (s_reg.linkS2[L_CAP]) begin
                s_next.chain = s_reg.upd;
                s_next.chain[POS_VERDICT] = s_reg.compS2;
                for (int p = 0; p < PORT_PINS; p++) begin
                    s_next.chain[pinCellPos(p, FLOP_DATA)] = s_reg.pinS2[p];
                end
            end else if (s_reg.linkS2[L_SHF]) begin
                // Low bit leaves first, new bit enters at the top
                s_next.chain = {s_reg.linkS2[L_TDI], s_reg.chain[CHAIN_LEN-1:1]};
            end else if (s_reg.linkS2[L_UPD]) begin
                s_next.upd = s_reg.chain;
            end
            s_next.extest = s_reg.linkS2[L_EXT];
        end
        // Tdo moves just after a fall, so it stands through the whole next high half
        if (tckFall) begin
            s_next.tdo = s_reg.chain[0];
        end

        // Under preload only the update stage loads; the analog block stays normal
        if (s_reg.extest) begin
            s_next.aOut = s_reg.upd[POS_ANALOG_HI:POS_ANALOG_LO];
            s_next.pOut = s_reg.upd[PORTA_BASE +: PORTA_W];
        end else begin
            s_next.aOut = normalSlice(normConvOn, s_reg.compS2, ~s_reg.busy);
            s_next.pOut = '0;
        end
        s_next.track = ~analogBit(s_next.aOut, POS_HOLD);

        // Dummy conversion on each enable while in normal mode
        s_next.convPrev = normConvOn;
        if (!s_reg.extest && normConvOn && !s_reg.convPrev) begin
            s_next.busy = 1'b1;
            s_next.compCount = 4'h0;
        end else if (s_reg.busy) begin
            if (s_reg.compCount == 4'(DUMMY_COMPS - 1)) begin
                s_next.busy = 1'b0;
            end
            s_next.compCount = s_reg.compCount + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= DEV_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.tdo     = s_reg.tdo;
    assign extestActive = s_reg.extest;
    assign convOn       = analogBit(s_reg.aOut, POS_CONV_ON);
    assign testLevel    = s_reg.aOut[POS_LEVEL_LO - POS_ANALOG_LO +: LEVEL_W];
    assign holdKeep     = analogBit(s_reg.aOut, POS_HOLD);
    assign sampleTrack  = s_reg.track;
    assign chanSel      = s_reg.aOut[POS_CHAN_LO - POS_ANALOG_LO +: CHAN_W];
    assign preloadN     = analogBit(s_reg.aOut, POS_PRELOAD);
    assign gndNeg       = analogBit(s_reg.aOut, POS_GNDEN);
    assign bandgapNeg   = analogBit(s_reg.aOut, POS_BANDGAP);
    assign negMuxSel    = analogBit(s_reg.aOut, POS_NEGMUX);
    assign dummyBusy    = s_reg.busy;

    always_comb begin
        for (int p = 0; p < PORT_PINS; p++) begin
            portAData[p]   = s_reg.pOut[pinCellPos(p, FLOP_DATA) - PORTA_BASE];
            portADir[p]    = s_reg.pOut[pinCellPos(p, FLOP_DIR) - PORTA_BASE];
            portAPullup[p] = s_reg.pOut[pinCellPos(p, FLOP_PULLUP) - PORTA_BASE];
        end
    end

endmodule : bscan_adc_device
`default_nettype wire

// ### hdl/bscan_adc_tester.sv
`timescale 1ns/1ns
`default_nettype none
module bscan_adc_tester
    import bscan_adc_pkg::*;
#(
    parameter int HALF_CYC = bscan_adc_pkg::TCK_HALF_CYC
)
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    bscan_link_if.tester                       link,
    input  wire logic                          start,
    input  wire logic [bscan_adc_pkg::LEVEL_W-1:0] lowLimit,
    input  wire logic [bscan_adc_pkg::LEVEL_W-1:0] highLimit,
    input  wire logic [bscan_adc_pkg::CHAN_W-1:0]  chanCode,
    output logic                               busy,
    output logic                               done,
    output logic                               belowOk,
    output logic                               aboveOk
);
    import bscan_adc_pkg::*;

    typedef enum logic [2:0] {
        T_IDLE   = 3'b000,
        T_CAPT   = 3'b001,
        T_SHIFT  = 3'b011,
        T_UPD    = 3'b010,
        T_SETTLE = 3'b110,
        T_DONE   = 3'b111
    } tst_fsm_t;

    typedef struct packed {
        tst_fsm_t             fsm;
        logic [7:0]           div;
        logic                 tck;
        logic                 tdi;
        logic                 ext;
        logic                 cap;
        logic                 sh;
        logic                 upd;
        logic                 tdoS1;
        logic                 tdoS2;
        logic [7:0]           bitCnt;
        logic [3:0]           step;
        logic [CHAIN_LEN-1:0] pat;
        logic [CHAIN_LEN-1:0] outBits;
        logic [7:0]           settleCnt;
        logic [LEVEL_W-1:0]   lo;
        logic [LEVEL_W-1:0]   hi;
        logic [CHAN_W-1:0]    chan;
        logic                 busy;
        logic                 done;
        logic                 below;
        logic                 above;
    } tst_state_t;

    tst_state_t s_reg;
    tst_state_t s_next;

    logic fallTick;

    // Test clock is a divider; fast enough for the keep time across five patterns
    assign fallTick = (s_reg.div == 8'(HALF_CYC - 1)) && s_reg.tck;

    always_comb begin
        s_next = s_reg;
        s_next.tdoS1 = link.tdo;
        s_next.tdoS2 = s_reg.tdoS1;
        s_next.div = s_reg.div + 8'h01;
        if (s_reg.div == 8'(HALF_CYC - 1)) begin
            s_next.div = 8'h00;
            s_next.tck = ~s_reg.tck;
        end
        if (s_reg.fsm == T_SETTLE && s_reg.settleCnt != 8'h00) begin
            s_next.settleCnt = s_reg.settleCnt - 8'h01;
        end

        if (s_reg.fsm == T_IDLE && start) begin
            s_next.lo = lowLimit;
            s_next.hi = highLimit;
            s_next.chan = chanCode;
            s_next.step = STEP_FIRST;
            s_next.pat = limitPattern(STEP_FIRST, lowLimit, highLimit, chanCode);
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.fsm = T_CAPT;
        end else if (fallTick) begin
            // Out bit of the last shift clock is valid just before this fall
            if (s_reg.sh) begin
                s_next.outBits = {s_reg.tdoS2, s_reg.outBits[CHAIN_LEN-1:1]};
            end
            case (s_reg.fsm)
                T_CAPT: begin
                    s_next.ext = (s_reg.step != STEP_FIRST);
                    s_next.cap = 1'b1;
                    s_next.bitCnt = 8'h00;
                    s_next.fsm = T_SHIFT;
                end
                T_SHIFT: begin
                    s_next.cap = 1'b0;
                    if (s_reg.bitCnt == 8'(CHAIN_LEN)) begin
                        s_next.sh = 1'b0;
                        s_next.upd = 1'b1;
                        s_next.fsm = T_UPD;
                    end else begin
                        s_next.sh = 1'b1;
                        s_next.tdi = s_reg.pat[0];
                        s_next.pat = {1'b0, s_reg.pat[CHAIN_LEN-1:1]};
                        s_next.bitCnt = s_reg.bitCnt + 8'h01;
                    end
                end
                T_UPD: begin
                    s_next.upd = 1'b0;
                    if (s_reg.step == STEP_LO_CHECK) begin
                        s_next.below = ~s_reg.outBits[POS_VERDICT];
                    end
                    if (s_reg.step == STEP_HI_CHECK) begin
                        s_next.above = s_reg.outBits[POS_VERDICT];
                    end
                    if (s_reg.step == STEP_FIRST) begin
                        s_next.settleCnt = 8'(SETTLE_CYC);
                        s_next.fsm = T_SETTLE;
                    end else if (s_reg.step == STEP_HI_CHECK) begin
                        s_next.fsm = T_DONE;
                    end else begin
                        s_next.fsm = T_CAPT;
                    end
                    s_next.step = s_reg.step + 4'h1;
                    // Midpoint while sampling, pin cells stay input without pull-up
                    s_next.pat = limitPattern(s_reg.step + 4'h1, s_reg.lo,
                                              s_reg.hi, s_reg.chan);
                end
                T_SETTLE: begin
                    if (s_reg.settleCnt == 8'h00) begin
                        s_next.fsm = T_CAPT;
                    end
                end
                T_DONE: begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.ext = 1'b0;
                    s_next.fsm = T_IDLE;
                end
                default: begin
                    s_next.fsm = T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{fsm: T_IDLE, div: 8'h00, tck: 1'b0, tdi: 1'b0, ext: 1'b0,
                       cap: 1'b0, sh: 1'b0, upd: 1'b0, tdoS1: 1'b0, tdoS2: 1'b0,
                       bitCnt: 8'h00, step: 4'h0, pat: '0, outBits: '0,
                       settleCnt: 8'h00, lo: '0, hi: '0, chan: '0, busy: 1'b0,
                       done: 1'b0, below: 1'b0, above: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.tck         = s_reg.tck;
    assign link.tdi         = s_reg.tdi;
    assign link.instrExtest = s_reg.ext;
    assign link.capture     = s_reg.cap;
    assign link.shift       = s_reg.sh;
    assign link.update      = s_reg.upd;
    assign busy             = s_reg.busy;
    assign done             = s_reg.done;
    assign belowOk          = s_reg.below;
    assign aboveOk          = s_reg.above;

endmodule : bscan_adc_tester
`default_nettype wire

// ### verification/bscan_adc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module bscan_adc_monitor
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic instrExtest,
    input wire logic capture,
    input wire logic shift,
    input wire logic update
);
    // One tck period is 8 clk, so a full scan is 198 periods of it
    localparam int SHIFT_CLKS = 198 * 8;

    logic [11:0] shiftCnt_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shiftCnt_reg <= 12'h000;
        end else if (shift) begin
            shiftCnt_reg <= shiftCnt_reg + 12'h001;
        end else begin
            shiftCnt_reg <= 12'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence tckHigh;
        tck[*4] ##1 !tck;
    endsequence
    sequence captureSlot;
        capture[*8] ##1 (!capture && shift);
    endsequence
    sequence updateSlot;
        update[*8] ##1 !update;
    endsequence

    tck_half_a: assert property ($rose(tck) |-> tckHigh)
        else $error("tck high phase has wrong length");
    tdi_at_fall_a: assert property ($changed(tdi) |-> $fell(tck))
        else $error("tdi changed away from a tck fall");
    tdo_low_phase_a: assert property ($changed(tdo) |-> !tck)
        else $error("tdo changed while tck high");
    phase_one_hot_a: assert property ($onehot0({capture, shift, update}))
        else $error("two scan phases active together");
    capture_slot_a: assert property ($rose(capture) |-> captureSlot)
        else $error("capture slot not one tck then shift");
    shift_length_a: assert property ($fell(shift) |-> shiftCnt_reg == SHIFT_CLKS)
        else $error("shift phase not a full chain length");
    update_slot_a: assert property ($fell(shift) |-> updateSlot)
        else $error("update does not follow shift for one tck");
    instr_steady_a: assert property (shift |-> $stable(instrExtest))
        else $error("instruction changed during shift");
endmodule : bscan_adc_monitor
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bscan_adc_pkg::*;

    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       compIn = 1'b0;
    logic       normConvOn = 1'b0;
    logic [7:0] portAIn = 8'h5A;
    logic       start = 1'b0;
    logic [9:0] lowLimit = 10'h123;
    logic [9:0] highLimit = 10'h143;
    logic [7:0] chanCode = 8'h08;
    logic [9:0] vin = 10'h12C;
    logic       watch = 1'b0;
    logic       extestActive, convOn, holdKeep, sampleTrack, preloadN;
    logic       gndNeg, bandgapNeg, negMuxSel, dummyBusy, busy, done, belowOk, aboveOk;
    logic [9:0] testLevel;
    logic [7:0] chanSel, portAData, portADir, portAPullup;
    logic       prevHold, prevPre, prevExt, seenExtest;
    int         holdFalls, preFalls;
    int         fail_count = 0;
    int         n_compared = 0;

    always #20 clk = ~clk;

    bscan_link_if link ();

    bscan_adc_device bscan_adc_device_i (.clk(clk), .nrst(nrst), .link(link),
        .compIn(compIn), .normConvOn(normConvOn), .portAIn(portAIn),
        .extestActive(extestActive), .convOn(convOn), .testLevel(testLevel),
        .holdKeep(holdKeep), .sampleTrack(sampleTrack), .chanSel(chanSel),
        .preloadN(preloadN), .gndNeg(gndNeg), .bandgapNeg(bandgapNeg),
        .negMuxSel(negMuxSel), .dummyBusy(dummyBusy), .portAData(portAData),
        .portADir(portADir), .portAPullup(portAPullup));

    bscan_adc_tester bscan_adc_tester_i (.clk(clk), .nrst(nrst), .link(link),
        .start(start), .lowLimit(lowLimit), .highLimit(highLimit),
        .chanCode(chanCode), .busy(busy), .done(done), .belowOk(belowOk),
        .aboveOk(aboveOk));

    bscan_adc_monitor bscan_adc_monitor_i (.clk(clk), .nrst(nrst), .tck(link.tck),
        .tdi(link.tdi), .tdo(link.tdo), .instrExtest(link.instrExtest),
        .capture(link.capture), .shift(link.shift), .update(link.update));

    // Stands in for the analog comparator against a fixed input voltage
    always @(posedge clk) compIn <= (testLevel > vin);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Watches the analog cells while the tester owns them; the cells follow the
    // update stage one clock after extest is latched, so that first clock is skipped
    always @(posedge clk) begin
        if (watch && extestActive === 1'b1 && prevExt === 1'b1) begin
            seenExtest = 1'b1;
            if (holdKeep === 1'b0) check("testLevel", LEVEL_MID, testLevel);
            check("sampleTrack", !holdKeep, sampleTrack);
            check("convOn", 1'b1, convOn);
            check("chanSel", CHAN_EXAMPLE, chanSel);
            check("negSources", 2'b00, {gndNeg, bandgapNeg});
            check("negMux", 1'b0, negMuxSel);
            check("pinDirPull", 2'b00, {portADir[SHARED_PIN], portAPullup[SHARED_PIN]});
            check("portAData", 8'h00, portAData);
            if (prevHold === 1'b1 && holdKeep === 1'b0) holdFalls++;
            if (prevPre === 1'b1 && preloadN === 1'b0) preFalls++;
        end
        prevHold = holdKeep;
        prevPre = preloadN;
        prevExt = extestActive;
    end

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic test_reset;
        check("holdKeep", 1'b1, holdKeep);
        check("preloadN", 1'b1, preloadN);
        check("chanSel", 8'h01, chanSel);
        check("convOn", 1'b0, convOn);
        check("busy", 1'b0, busy);
        $display("test reset done");
    endtask : test_reset

    task automatic test_dummy;
        int highCnt;
        highCnt = 0;
        @(posedge clk);
        normConvOn <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (dummyBusy === 1'b1) highCnt++;
        end
        check("dummyCycles", DUMMY_COMPS, highCnt);
        @(posedge clk);
        normConvOn <= 1'b0;
        $display("test dummy conversion done");
    endtask : test_dummy

    task automatic run_limit(input logic [9:0] vinCode, input logic expBelow,
                             input logic expAbove);
        int n;
        logic [CHAIN_LEN-1:0] scanOut;
        // Let the previous run's extest fall away so extestSeen is earned afresh
        while (extestActive !== 1'b0) @(posedge clk);
        vin = vinCode;
        holdFalls = 0;
        preFalls = 0;
        seenExtest = 1'b0;
        @(posedge clk);
        start <= 1'b1;
        watch <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 40000);
        watch <= 1'b0;
        check("done", 1'b1, done);
        check("extestSeen", 1'b1, seenExtest);
        check("holdFalls", 2, holdFalls);
        check("preloadFalls", 2, preFalls);
        check("belowOk", expBelow, belowOk);
        check("aboveOk", expAbove, aboveOk);
        // Last scan out: verdict at 193, pin p data cell at (7-p)*3
        scanOut = bscan_adc_tester_i.s_reg.outBits;
        check("verdictCell", expAbove, scanOut[193]);
        for (int p = 0; p < 8; p++) begin
            check("portACell", portAIn[p], scanOut[21 - 3 * p]);
        end
        $display("test limit run vin %0h done", vinCode);
    endtask : run_limit

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        test_reset();
        test_dummy();
        run_limit(10'h12C, 1'b1, 1'b1);
        run_limit(10'h100, 1'b0, 1'b1);
        run_limit(10'h150, 1'b1, 1'b0);
        end_of_test();
    end

    initial begin
        #(90000 * 40);
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
